// ===== logic/irm_defines.svh
/*
  register offsets, field positions, reset values and timing counts of the infrared modem.
  assumes inclusion by bare name from the modem sources.
*/
`ifndef IRM_DEFINES_SVH
`define IRM_DEFINES_SVH

`define IRM_OFF_CTRL_CH0        16'h1207
`define IRM_OFF_CTRL_CH1        16'h120f
`define IRM_OFF_CTRL_CH2        16'h1217
`define IRM_OFF_STATUS          16'h1218

`define IRM_BIT_TX_WIDTH_SEL    7
`define IRM_BIT_RX_POLARITY     6
`define IRM_BIT_TX_ENABLE       5
`define IRM_BIT_RX_ENABLE       4
`define IRM_FLD_RX_WIDTH_LSB    0
`define IRM_FLD_RX_WIDTH_MSB    3

`define IRM_CTRL_RESET          8'h00
`define IRM_RDATA_IDLE          8'h00

`define IRM_TX_TICKS_WIDE       2'h3
`define IRM_TX_TICKS_NARROW     2'h1
`define IRM_RX_HOLD_TICKS       5'h10

`define IRM_MCLK_KHZ            40000
`define IRM_RX_EXTRA_NS         100
`define IRM_RX_EXTRA_CYC        ((`IRM_RX_EXTRA_NS * `IRM_MCLK_KHZ + 999999) / 1000000)

`endif

// ===== logic/irm_pkg.sv
/*
  types and shared arithmetic of the infrared modem.
  assumes nothing of its surroundings.
*/
package irm_pkg;

  typedef struct packed {
    logic       tx_pulse_width_sel;
    logic       rx_pulse_polarity_sel;
    logic       tx_modem_enable;
    logic       rx_modem_enable;
    logic [3:0] rx_min_width_field;
  } irm_ctrl_type;

  // least pulse length in prescaler periods: 2 x (field + 1), wrapping to 0 for field 15
  function automatic logic [4:0] irm_min_ticks(input logic [3:0] wd);
    irm_min_ticks = {wd, 1'b0} + 5'h02;
  endfunction

endpackage

// ===== logic/irm_channel.sv
/*
  one infrared modem channel: zero-bit pulse modulation and qualified-pulse demodulation.
  assumes tick, bit start and transmit bit from the serial channel on mclk, rx level already
  synchronised.
*/
`timescale 1ns/1ps
`include "irm_defines.svh"

module irm_channel (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  irm_pkg::irm_ctrl_type ctrl,
  input  wire logic             tick16,
  input  wire logic             bit_start,
  input  wire logic             tx_bit,
  input  wire logic             prescale_tick,
  input  wire logic             rx_level,
  output logic                  ir_tx_ff,
  output logic                  rxd_ff,
  output logic                  rx_qual_ff
);

  logic [1:0] tx_cnt_ff;
  logic [1:0] nxt_tx_cnt;
  logic [4:0] x_cnt_ff;
  logic [4:0] nxt_x_cnt;
  logic [2:0] ns_cnt_ff;
  logic [2:0] nxt_ns_cnt;
  logic [4:0] hold_ff;
  logic [4:0] nxt_hold;

  wire [1:0] tx_width = ctrl.tx_pulse_width_sel ? `IRM_TX_TICKS_NARROW
                                                : `IRM_TX_TICKS_WIDE;
  wire       rx_act   = rx_level ^ ctrl.rx_pulse_polarity_sel;
  wire [4:0] thr      = irm_pkg::irm_min_ticks(ctrl.rx_min_width_field);
  wire       x_done   = x_cnt_ff >= thr;
  wire       qual     = x_done && (ns_cnt_ff >= 3'(`IRM_RX_EXTRA_CYC));
  wire       rx_run   = ctrl.rx_modem_enable && rx_act;

  // a zero bit loads the pulse length, each sixteenth tick takes one off
  assign nxt_tx_cnt = !ctrl.tx_modem_enable ? 2'h0 :
                      (bit_start && !tx_bit) ? tx_width :
                      (tick16 && tx_cnt_ff != 2'h0) ? tx_cnt_ff - 2'h1 : tx_cnt_ff;

  assign nxt_x_cnt  = !rx_run ? 5'h00 :
                      (prescale_tick && !x_done) ? x_cnt_ff + 5'h01 : x_cnt_ff;
  assign nxt_ns_cnt = !rx_run ? 3'h0 :
                      (x_done && !qual) ? ns_cnt_ff + 3'h1 : ns_cnt_ff;

  // a qualified pulse holds the serial input low for one bit
  assign nxt_hold   = !ctrl.rx_modem_enable ? 5'h00 :
                      (rx_run && qual) ? `IRM_RX_HOLD_TICKS :
                      (tick16 && hold_ff != 5'h00) ? hold_ff - 5'h01 : hold_ff;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_cnt_ff  <= 2'h0;
      x_cnt_ff   <= 5'h00;
      ns_cnt_ff  <= 3'h0;
      hold_ff    <= 5'h00;
      ir_tx_ff   <= 1'b0;
      rxd_ff     <= 1'b1;
      rx_qual_ff <= 1'b0;
    end
    else
    begin
      tx_cnt_ff  <= nxt_tx_cnt;
      x_cnt_ff   <= nxt_x_cnt;
      ns_cnt_ff  <= nxt_ns_cnt;
      hold_ff    <= nxt_hold;
      ir_tx_ff   <= nxt_tx_cnt != 2'h0;
      rxd_ff     <= nxt_hold == 5'h00;
      rx_qual_ff <= rx_run && qual;
    end
  end

endmodule

// ===== logic/irm_modem.sv
/*
  three-channel infrared modem with its control registers on a plain register port.
  assumes serial channels and prescaler tick on mclk; infrared receive pins are asynchronous.
*/
// The strobed register port was chosen for this implementation.
// What this block does
// - transmit pulse 3/16 or 1/16 by select bit
// - nominal pulse is three sixteenths of bit time
// - polarity bit picks high or low valid pulses
// - receive enable off ignores infrared input
// - transmit enable off ignores data, no pulses
// - accept pulse lasting 2x(field+1) plus 100 ns, field 15 wraps to 100 ns alone
// - zero bit drives pin high, one stays low
// - qualified pulse gives 0, otherwise 1
`timescale 1ns/1ps
`include "irm_defines.svh"

module irm_modem (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata_ff,
  input  wire logic [2:0]  sio_tick16,
  input  wire logic [2:0]  sio_bit_start,
  input  wire logic [2:0]  sio_tx_bit,
  input  wire logic        prescale_tick,
  input  wire logic [2:0]  ir_rx_pin,
  output logic      [2:0]  ir_tx_pin,
  output logic      [2:0]  sio_rxd
);

  irm_pkg::irm_ctrl_type ctrl_ff [3];
  logic [2:0]            rx_meta_ff;
  logic [2:0]            rx_sync_ff;
  logic [2:0]            rx_qual;
  logic [7:0]            nxt_rdata;

  wire [2:0] hit;
  assign hit[0] = reg_addr == `IRM_OFF_CTRL_CH0;
  assign hit[1] = reg_addr == `IRM_OFF_CTRL_CH1;
  assign hit[2] = reg_addr == `IRM_OFF_CTRL_CH2;
  wire hit_stat = reg_addr == `IRM_OFF_STATUS;
  wire [7:0] status = {2'h0, rx_qual, ir_tx_pin};

  assign nxt_rdata = !reg_rd ? `IRM_RDATA_IDLE :
                     hit[0]  ? ctrl_ff[0] :
                     hit[1]  ? ctrl_ff[1] :
                     hit[2]  ? ctrl_ff[2] :
                     hit_stat ? status : `IRM_RDATA_IDLE;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_meta_ff   <= 3'h0;
      rx_sync_ff   <= 3'h0;
      reg_rdata_ff <= `IRM_RDATA_IDLE;
    end
    else
    begin
      rx_meta_ff   <= ir_rx_pin;
      rx_sync_ff   <= rx_meta_ff;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_ch
      // each channel keeps its own register and state
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          ctrl_ff[i] <= `IRM_CTRL_RESET;
        else if (reg_wr && hit[i])
          ctrl_ff[i] <= reg_wdata;
      end

      irm_channel u_ch (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .ctrl          (ctrl_ff[i]),
        .tick16        (sio_tick16[i]),
        .bit_start     (sio_bit_start[i]),
        .tx_bit        (sio_tx_bit[i]),
        .prescale_tick (prescale_tick),
        .rx_level      (rx_sync_ff[i]),
        .ir_tx_ff      (ir_tx_pin[i]),
        .rxd_ff        (sio_rxd[i]),
        .rx_qual_ff    (rx_qual[i])
      );
    end
  endgenerate

  // helper logic for the checks on channel zero
  logic [4:0] h_txticks_ff;
  logic [5:0] h_xticks_ff;
  wire        c0_act = rx_sync_ff[0] ^ ctrl_ff[0].rx_pulse_polarity_sel;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      h_txticks_ff <= 5'h00;
      h_xticks_ff  <= 6'h00;
    end
    else
    begin
      h_txticks_ff <= !ir_tx_pin[0] ? 5'h00 :
                      sio_tick16[0] ? h_txticks_ff + 5'h01 : h_txticks_ff;
      h_xticks_ff  <= !c0_act ? 6'h00 :
                      (prescale_tick && h_xticks_ff != 6'h3f) ? h_xticks_ff + 6'h01 : h_xticks_ff;
    end
  end

  property p_tx_off_quiet;
    @(posedge mclk) disable iff (!rst_n)
    (!ctrl_ff[0].tx_modem_enable && $past(!ctrl_ff[0].tx_modem_enable)) |-> !ir_tx_pin[0];
  endproperty
  a_tx_off_quiet: assert property (p_tx_off_quiet) else $error("pulse while transmit off");

  property p_rx_off_idle;
    @(posedge mclk) disable iff (!rst_n)
    (!ctrl_ff[0].rx_modem_enable && $past(!ctrl_ff[0].rx_modem_enable)) |-> sio_rxd[0];
  endproperty
  a_rx_off_idle: assert property (p_rx_off_idle) else $error("serial input low while rx off");

  property p_tx_width;
    @(posedge mclk) disable iff (!rst_n)
    ($fell(ir_tx_pin[0]) && $stable(ctrl_ff[0]) && ctrl_ff[0].tx_modem_enable &&
     !$past(sio_bit_start[0]))
      |-> h_txticks_ff == (ctrl_ff[0].tx_pulse_width_sel ? 5'h01 : 5'h03);
  endproperty
  a_tx_width: assert property (p_tx_width) else $error("transmit pulse width wrong");

  property p_tx_nominal;
    @(posedge mclk) disable iff (!rst_n)
    (sio_bit_start[0] && !sio_tx_bit[0] && ctrl_ff[0].tx_modem_enable &&
     !ctrl_ff[0].tx_pulse_width_sel) |=> ir_tx_pin[0] [*3];
  endproperty
  a_tx_nominal: assert property (p_tx_nominal) else $error("nominal pulse cut short");

  property p_zero_starts;
    @(posedge mclk) disable iff (!rst_n)
    (sio_bit_start[0] && !sio_tx_bit[0] && ctrl_ff[0].tx_modem_enable) |=> ir_tx_pin[0];
  endproperty
  a_zero_starts: assert property (p_zero_starts) else $error("zero bit gave no pulse");

  property p_one_quiet;
    @(posedge mclk) disable iff (!rst_n)
    (sio_bit_start[0] && sio_tx_bit[0] && !ir_tx_pin[0]) |=> !ir_tx_pin[0];
  endproperty
  a_one_quiet: assert property (p_one_quiet) else $error("one bit produced a pulse");

  property p_rx_min_width;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rx_qual[0]) |->
      $past(h_xticks_ff) >= 6'(irm_pkg::irm_min_ticks(ctrl_ff[0].rx_min_width_field));
  endproperty
  a_rx_min_width: assert property (p_rx_min_width) else $error("pulse accepted too short");

  property p_rx_extra;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rx_qual[0]) |-> $past(c0_act, 1) && $past(c0_act, 2) && $past(c0_act, 3) && $past(c0_act, 4);
  endproperty
  a_rx_extra: assert property (p_rx_extra) else $error("pulse accepted without 100 ns margin");

  property p_rx_polarity;
    @(posedge mclk) disable iff (!rst_n)
    $rose(rx_qual[0]) |-> $past(rx_sync_ff[0]) != $past(ctrl_ff[0].rx_pulse_polarity_sel);
  endproperty
  a_rx_polarity: assert property (p_rx_polarity) else $error("pulse of wrong polarity accepted");

  property p_rx_zero;
    @(posedge mclk) disable iff (!rst_n)
    rx_qual[0] |-> !sio_rxd[0];
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("qualified pulse did not give zero");

  property p_rx_one;
    @(posedge mclk) disable iff (!rst_n)
    $fell(sio_rxd[0]) |-> rx_qual[0];
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("zero without qualified pulse");

  property p_ch_isolated;
    @(posedge mclk) disable iff (!rst_n)
    (reg_wr && !hit[0]) |=> $stable(ctrl_ff[0]);
  endproperty
  a_ch_isolated: assert property (p_ch_isolated) else $error("foreign write changed channel 0");

  property p_read_ctrl1;
    @(posedge mclk) disable iff (!rst_n)
    (reg_rd && hit[1]) |=> reg_rdata_ff == $past(ctrl_ff[1]);
  endproperty
  a_read_ctrl1: assert property (p_read_ctrl1) else $error("read of channel 1 control wrong");

  property p_rdata_idle;
    @(posedge mclk) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata_ff == `IRM_RDATA_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  property p_status_tx;
    @(posedge mclk) disable iff (!rst_n)
    (reg_rd && hit_stat) |=> reg_rdata_ff[2:0] == $past(ir_tx_pin);
  endproperty
  a_status_tx: assert property (p_status_tx) else $error("status shows wrong pin state");

  c_tx_narrow: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(ir_tx_pin[0]) && ctrl_ff[0].tx_pulse_width_sel);
  c_tx_wide: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(ir_tx_pin[0]) && !ctrl_ff[0].tx_pulse_width_sel);
  c_rx_low_pol: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(rx_qual[0]) && ctrl_ff[0].rx_pulse_polarity_sel);
  c_status_read: cover property (@(posedge mclk) disable iff (!rst_n) reg_rd && hit_stat);
  c_rx_high_pol: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(rx_qual[0]) && !ctrl_ff[0].rx_pulse_polarity_sel);

endmodule

// ===== test/irm_xcvr.sv
/*
  infrared transceiver model: emits commanded receive pulses, measures transmit pulses.
  assumes the modem clock; the line is always driven, idle at the inactive level.
*/
`timescale 1ns/1ps

module irm_xcvr (
  input  wire logic       mclk,
  input  wire logic       tx_led,
  input  wire logic       pol,
  input  wire logic [7:0] len,
  input  wire logic       go,
  output logic            rx_out,
  output logic      [7:0] tx_width
);
  logic [7:0] run_ff = 8'h00;
  logic [7:0] hi_ff  = 8'h00;

  // pulses are low-going when pol is set
  assign rx_out = (run_ff != 8'h00) ^ pol;

  always_ff @(posedge mclk)
  begin
    run_ff <= go ? len : run_ff - {7'h00, run_ff != 8'h00};
    hi_ff  <= tx_led ? hi_ff + 8'h01 : 8'h00;
    if (go)
      tx_width <= 8'h00;
    else if (!tx_led && hi_ff != 8'h00)
      tx_width <= hi_ff;
  end
endmodule

// ===== test/irm_modem_bench.sv
/*
  self-checking bench of the three-channel infrared modem.
  assumes the transceiver model and the modem sources.
*/
`timescale 1ns/1ps

module irm_modem_bench;
  logic        mclk          = 1'b0;
  logic        rst_n         = 1'b0;
  logic [15:0] reg_addr      = 16'h0000;
  logic [7:0]  reg_wdata     = 8'h00;
  logic        reg_wr        = 1'b0;
  logic        reg_rd        = 1'b0;
  logic [7:0]  reg_rdata_ff;
  logic [2:0]  sio_tick16    = 3'h0;
  logic [2:0]  sio_bit_start = 3'h0;
  logic [2:0]  sio_tx_bit    = 3'h7;
  logic        prescale_tick = 1'b0;
  logic [2:0]  ir_tx_pin;
  logic [2:0]  sio_rxd;
  logic        rx_line;
  logic [6:0]  tcnt          = 7'h00;
  logic [1:0]  ch            = 2'h0;
  logic        pol           = 1'b0;
  logic        go            = 1'b0;
  logic [7:0]  len           = 8'h00;
  logic [7:0]  tx_width;
  logic [7:0]  rdv;
  logic        seen;
  logic        leak;
  int          error_cnt     = 0;
  int          n_checks      = 0;
  int          cyc           = 0;
  logic [31:0] reg_rows [6]  = '{32'h1207_37_37, 32'h120f_a5_a5, 32'h1217_9a_9a,
                                 32'h1206_55_00, 32'h1218_ff_00, 32'h1207_ce_ce};
  logic [19:0] tx_rows [4]   = '{20'h21_0_c6, 20'ha1_0_42, 20'h21_1_00, 20'h81_0_00};
  logic [23:0] rx_rows [6]   = '{24'h11_0_1e_1, 24'h11_0_06_0, 24'h51_1_1e_1,
                                 24'h01_0_1e_0, 24'h1e_0_32_0, 24'h1e_0_5a_1};

  irm_modem u_dut (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata_ff  (reg_rdata_ff),
    .sio_tick16    (sio_tick16),
    .sio_bit_start (sio_bit_start),
    .sio_tx_bit    (sio_tx_bit),
    .prescale_tick (prescale_tick),
    .ir_rx_pin     ({3{rx_line}}),
    .ir_tx_pin     (ir_tx_pin),
    .sio_rxd       (sio_rxd)
  );

  irm_xcvr u_xcvr (
    .mclk     (mclk),
    .tx_led   (ir_tx_pin[ch]),
    .pol      (pol),
    .len      (len),
    .go       (go),
    .rx_out   (rx_line),
    .tx_width (tx_width)
  );

  always #12.5 mclk = ~mclk;

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // baud x16 tick every 66 cycles from a whole divider, at most 38.4 kbps; prescaler every 2
  always @(posedge mclk)
  begin
    tcnt <= (tcnt == 7'h41) ? 7'h00 : tcnt + 7'h01;
    sio_tick16 <= {3{tcnt == 7'h41}};
    prescale_tick <= ~prescale_tick;
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata_ff;
  endtask

  task automatic pulse_go;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++)
    begin
      rd(16'h1207 + 16'(8 * i), rdv);
      check(rdv, 8'h00);
    end
    check({5'h00, ir_tx_pin}, 8'h00);
    check({5'h00, sio_rxd}, 8'h07);
    foreach (reg_rows[i])
    begin
      wr(reg_rows[i][31:16], reg_rows[i][15:8]);
      rd(reg_rows[i][31:16], rdv);
      check(rdv, reg_rows[i][7:0]);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(16'h1207, rdv);
    check(rdv, 8'h00);
    for (int c = 0; c < 3; c++)
      foreach (tx_rows[i])
      begin
        ch <= 2'(c);
        wr(16'h1207 + 16'(8 * c), tx_rows[i][19:12]);
        pulse_go();
        while (tcnt !== 7'h41)
          @(posedge mclk);
        sio_bit_start[c] <= 1'b1;
        sio_tx_bit[c] <= tx_rows[i][8];
        @(posedge mclk);
        sio_bit_start[c] <= 1'b0;
        rd(16'h1218, rdv);
        check(rdv, (tx_rows[i][7:0] != 8'h00) ? (8'h01 << c) : 8'h00);
        repeat (208) @(posedge mclk);
        check(tx_width, tx_rows[i][7:0]);
      end
    ch <= 2'h0;
    foreach (rx_rows[i])
    begin
      wr(16'h1207, 8'h01);
      pol <= rx_rows[i][12];
      repeat (8) @(posedge mclk);
      wr(16'h1207, rx_rows[i][23:16]);
      len <= rx_rows[i][11:4];
      pulse_go();
      seen = 1'b0;
      leak = 1'b0;
      repeat (120)
      begin
        @(posedge mclk);
        seen |= (sio_rxd[0] === 1'b0);
        leak |= (sio_rxd[1] !== 1'b1) | (sio_rxd[2] !== 1'b1);
      end
      check({7'h00, seen}, {7'h00, rx_rows[i][0]});
      check({7'h00, leak}, 8'h00);
      repeat (100) @(posedge mclk);
    end
    end_of_test();
  end
endmodule
